// ---- fsq_pkg.sv ----
// constants and types shared by the flash command sequencer host
package fsq_pkg;
  localparam int ADDR_W        = 21;
  localparam int DATA_W        = 16;
  localparam int CLK_NS        = 4;
  localparam int T_SETUP_NS    = 20;
  localparam int T_WPULSE_NS   = 40;
  localparam int T_HOLD_NS     = 20;
  localparam int T_ACCESS_NS   = 70;
  localparam int T_SUSPEND_NS  = 20000;
  localparam int SYNC_LAG      = 2;
  localparam int SETUP_CYC     = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPULSE_CYC    = (T_WPULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC      = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CYC    = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_LAG;
  localparam int SUSPEND_CYC   = (T_SUSPEND_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W         = 8;
  localparam int SUSP_W        = 13;
  localparam logic [CNT_W-1:0] SETUP_LD  = CNT_W'(SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] WPULSE_LD = CNT_W'(WPULSE_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LD   = CNT_W'(HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] ACCESS_LD = CNT_W'(ACCESS_CYC - 1);
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1   = 21'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2   = 21'h0002aa;
  localparam logic [ADDR_W-1:0] DONT_CARE_ADDR = 21'h000000;
  localparam logic [ADDR_W-1:0] SECTOR_MASK    = 21'h1ff000;
  localparam logic [DATA_W-1:0] CMD_UNLOCK1    = 16'h00aa;
  localparam logic [DATA_W-1:0] CMD_UNLOCK2    = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_PROGRAM    = 16'h00a0;
  localparam logic [DATA_W-1:0] CMD_ERASE_SET  = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 16'h0010;
  localparam logic [DATA_W-1:0] CMD_SECT_ERASE = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_SUSPEND    = 16'h00b0;
  localparam logic [DATA_W-1:0] CMD_RESUME     = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_BYP_ENTER  = 16'h0020;
  localparam logic [DATA_W-1:0] CMD_BYP_RESET1 = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_BYP_RESET2 = 16'h0000;
  localparam logic [DATA_W-1:0] CMD_RESET      = 16'h00f0;
  localparam int TOGGLE_BIT  = 6;
  localparam int TIMEOUT_BIT = 5;
  typedef enum logic [3:0] {
    OP_READ, OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SUSPEND,
    OP_RESUME, OP_BYPASS_ENTER, OP_BYPASS_RESET, OP_RESET
  } fsq_op_t;
  typedef enum logic [2:0] {E_IDLE, E_SETUP, E_PULSE, E_HOLD, E_READ, E_GAP} fsq_eng_state_t;
  typedef enum logic [2:0] {ST_IDLE, ST_SEQ, ST_POLL1, ST_POLL2, ST_SUSP_WAIT} fsq_state_t;
endpackage : fsq_pkg

// ---- fsq_bus_cycle.sv ----
// one write or read cycle on the flash strobe bus
`timescale 1ns/1ns
`default_nettype none
module fsq_bus_cycle
  import fsq_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  input  wire logic              i_req,
  input  wire logic              i_write,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  output logic                   o_idle,
  output logic                   o_done,
  output logic      [DATA_W-1:0] o_rdata,
  output logic                   o_flash_ce_n,
  output logic                   o_flash_we_n,
  output logic                   o_flash_oe_n,
  output logic      [ADDR_W-1:0] o_flash_addr,
  output logic      [DATA_W-1:0] o_flash_dq_out,
  output logic                   o_flash_dq_oe,
  input  wire logic [DATA_W-1:0] i_flash_dq
);
  typedef struct packed {
    fsq_eng_state_t    st;
    logic [CNT_W-1:0]  cnt;
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic              dq_oe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              done;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
  } fsq_eng_s_t;

  localparam fsq_eng_s_t ENG_RST = '{st: E_IDLE, cnt: '0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                     dq_oe: 1'b0, addr: '0, wdata: '0, rdata: '0, done: 1'b0,
                                     dq_s1: '0, dq_s2: '0};
  fsq_eng_s_t r_r;
  fsq_eng_s_t r_nxt;

  always_comb begin
    r_nxt = r_r;
    r_nxt.done = 1'b0;
    r_nxt.dq_s1 = i_flash_dq;
    r_nxt.dq_s2 = r_r.dq_s1;
    if (r_r.cnt != '0) begin
      r_nxt.cnt = r_r.cnt - CNT_W'(1);
    end
    unique case (r_r.st)
      E_IDLE: if (i_req) begin
        // chip enable falls first so the write strobe falls last and latches the address
        r_nxt.addr = i_addr;
        r_nxt.wdata = i_wdata;
        r_nxt.ce_n = 1'b0;
        if (i_write) begin
          r_nxt.dq_oe = 1'b1;
          r_nxt.cnt = SETUP_LD;
          r_nxt.st = E_SETUP;
        end else begin
          r_nxt.oe_n = 1'b0;
          r_nxt.cnt = ACCESS_LD;
          r_nxt.st = E_READ;
        end
      end
      E_SETUP: if (r_r.cnt == '0) begin
        r_nxt.we_n = 1'b0;
        r_nxt.cnt = WPULSE_LD;
        r_nxt.st = E_PULSE;
      end
      E_PULSE: if (r_r.cnt == '0) begin
        // write strobe rises before chip enable, data still driven
        r_nxt.we_n = 1'b1;
        r_nxt.cnt = HOLD_LD;
        r_nxt.st = E_HOLD;
      end
      E_HOLD: if (r_r.cnt == '0) begin
        r_nxt.ce_n = 1'b1;
        r_nxt.dq_oe = 1'b0;
        r_nxt.done = 1'b1;
        r_nxt.cnt = HOLD_LD;
        r_nxt.st = E_GAP;
      end
      E_READ: if (r_r.cnt == '0) begin
        // access time includes the synchroniser lag
        r_nxt.rdata = r_r.dq_s2;
        r_nxt.ce_n = 1'b1;
        r_nxt.oe_n = 1'b1;
        r_nxt.done = 1'b1;
        r_nxt.cnt = HOLD_LD;
        r_nxt.st = E_GAP;
      end
      E_GAP: if (r_r.cnt == '0) begin
        r_nxt.st = E_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_r <= ENG_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign o_idle         = (r_r.st == E_IDLE);
  assign o_done         = r_r.done;
  assign o_rdata        = r_r.rdata;
  assign o_flash_ce_n   = r_r.ce_n;
  assign o_flash_we_n   = r_r.we_n;
  assign o_flash_oe_n   = r_r.oe_n;
  assign o_flash_addr   = r_r.addr;
  assign o_flash_dq_out = r_r.wdata;
  assign o_flash_dq_oe  = r_r.dq_oe;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_strobe_low;
    !o_flash_we_n && !o_flash_ce_n;
  endsequence

  chk_we_inside_ce: assert property (!o_flash_we_n |-> !o_flash_ce_n)
    else $error("write strobe low outside chip enable");
  chk_addr_stable: assert property ((!o_flash_ce_n && $past(!o_flash_ce_n)) |-> $stable(o_flash_addr))
    else $error("address moved during a bus cycle");
  chk_data_at_rise: assert property ($rose(o_flash_we_n) |-> (o_flash_dq_oe && !o_flash_ce_n && $stable(o_flash_dq_out)))
    else $error("data not held at first rising strobe");
  chk_pulse_width: assert property ($fell(o_flash_we_n) |-> s_strobe_low [*8])
    else $error("write pulse too short");
endmodule : fsq_bus_cycle
`default_nettype wire

// ---- fsq_host.sv ----
// host controller that issues program and erase command sequences to a parallel flash
// How it works
// - normal program is unlock, unlock, program setup, then address and data write.
// - chip erase is six writes ending with the chip erase code.
// - sector erase is six writes ending with sector address and erase code.
// - one sector per erase order; an order given before completion is refused, except a suspend while a sector erase is polled.
`timescale 1ns/1ns
`default_nettype none
module fsq_host
  import fsq_pkg::*;
#(
  parameter int SUSP_WAIT_CYC = SUSPEND_CYC
) (
  input  wire logic              i_clock,
  input  wire logic              i_nrst,
  input  wire logic              i_start,
  input  wire fsq_op_t           i_op,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_data,
  input  wire logic              i_accel_req,
  output logic                   o_ready,
  output logic                   o_done,
  output logic                   o_refused,
  output logic                   o_fail,
  output logic      [DATA_W-1:0] o_rdata,
  output logic                   o_bypass,
  output logic                   o_suspended,
  output logic                   o_high_program_voltage,
  output logic                   o_flash_ce_n,
  output logic                   o_flash_we_n,
  output logic                   o_flash_oe_n,
  output logic      [ADDR_W-1:0] o_flash_addr,
  output logic      [DATA_W-1:0] o_flash_dq_out,
  output logic                   o_flash_dq_oe,
  input  wire logic [DATA_W-1:0] i_flash_dq
);
  typedef struct packed {
    fsq_state_t        st;
    fsq_op_t           op;
    logic [2:0]        idx;
    logic              sent;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              byp_op;
    logic              bit6;
    logic              t5;
    logic              fail;
    logic              done;
    logic              refused;
    logic              bypass;
    logic              accel;
    logic              suspended;
    logic              erase_run;
    logic [DATA_W-1:0] rdata;
    logic [SUSP_W-1:0] susp_cnt;
  } fsq_host_s_t;

  logic [1:0]        rst_q;
  logic              rst_n;
  fsq_host_s_t       r_r;
  fsq_host_s_t       r_nxt;
  logic              eng_idle;
  logic              eng_done;
  logic [DATA_W-1:0] eng_rdata;
  logic              eng_req;
  logic              eng_write;
  logic [ADDR_W+DATA_W-1:0] cur_word;
  logic              susp_ok;
  logic              allowed;
  logic              byp_eff;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  function automatic logic [2:0] seq_last(input fsq_op_t op, input logic byp);
    case (op)
      OP_PROGRAM:                     seq_last = byp ? 3'h1 : 3'h3;
      OP_CHIP_ERASE, OP_SECTOR_ERASE: seq_last = 3'h5;
      OP_BYPASS_ENTER:                seq_last = 3'h2;
      OP_BYPASS_RESET:                seq_last = 3'h1;
      default:                        seq_last = 3'h0;
    endcase
  endfunction : seq_last

  function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input fsq_op_t op, input logic byp, input logic [2:0] idx,
                                           input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    seq_word = {DONT_CARE_ADDR, CMD_RESET};
    case (op)
      OP_PROGRAM: begin
        if (byp) begin
          seq_word = (idx == 3'h0) ? {DONT_CARE_ADDR, CMD_PROGRAM} : {a, d};
        end else begin
          case (idx)
            3'h0:    seq_word = {UNLOCK_ADDR1, CMD_UNLOCK1};
            3'h1:    seq_word = {UNLOCK_ADDR2, CMD_UNLOCK2};
            3'h2:    seq_word = {UNLOCK_ADDR1, CMD_PROGRAM};
            default: seq_word = {a, d};
          endcase
        end
      end
      OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
        case (idx)
          3'h0, 3'h3: seq_word = {UNLOCK_ADDR1, CMD_UNLOCK1};
          3'h1, 3'h4: seq_word = {UNLOCK_ADDR2, CMD_UNLOCK2};
          3'h2:       seq_word = {UNLOCK_ADDR1, CMD_ERASE_SET};
          default:    seq_word = (op == OP_CHIP_ERASE) ? {UNLOCK_ADDR1, CMD_CHIP_ERASE}
                                                       : {a & SECTOR_MASK, CMD_SECT_ERASE};
        endcase
      end
      OP_BYPASS_ENTER: begin
        case (idx)
          3'h0:    seq_word = {UNLOCK_ADDR1, CMD_UNLOCK1};
          3'h1:    seq_word = {UNLOCK_ADDR2, CMD_UNLOCK2};
          default: seq_word = {UNLOCK_ADDR1, CMD_BYP_ENTER};
        endcase
      end
      OP_BYPASS_RESET: seq_word = {DONT_CARE_ADDR, (idx == 3'h0) ? CMD_BYP_RESET1 : CMD_BYP_RESET2};
      OP_SUSPEND:      seq_word = {DONT_CARE_ADDR, CMD_SUSPEND};
      OP_RESUME:       seq_word = {DONT_CARE_ADDR, CMD_RESUME};
      OP_READ:         seq_word = {a, d};
      default:         seq_word = {DONT_CARE_ADDR, CMD_RESET};
    endcase
  endfunction : seq_word

  assign byp_eff  = r_r.bypass | r_r.accel;
  assign cur_word = seq_word(r_r.op, r_r.byp_op, r_r.idx, r_r.addr, r_r.data);
  // a suspend is only meaningful while a sector erase is being polled
  assign susp_ok  = i_start && (i_op == OP_SUSPEND) && (r_r.st == ST_POLL1) && !r_r.sent && r_r.erase_run
                    && ((r_r.op == OP_SECTOR_ERASE) || (r_r.op == OP_RESUME));
  assign eng_write = (r_r.st == ST_SEQ) && (r_r.op != OP_READ);
  assign eng_req   = ((r_r.st == ST_SEQ) || (r_r.st == ST_POLL1) || (r_r.st == ST_POLL2))
                     && !r_r.sent && eng_idle && !susp_ok;

  always_comb begin
    allowed = 1'b0;
    if (byp_eff) begin
      allowed = (i_op == OP_PROGRAM) || (i_op == OP_BYPASS_RESET) || (i_op == OP_READ);
    end else if (r_r.suspended) begin
      // bypass entry and erase orders are never sent while suspended
      allowed = (i_op == OP_READ) || (i_op == OP_PROGRAM) || (i_op == OP_RESUME) || (i_op == OP_RESET);
    end else begin
      allowed = (i_op != OP_SUSPEND) && (i_op != OP_RESUME) && (i_op != OP_BYPASS_RESET);
    end
  end

  always_comb begin
    r_nxt = r_r;
    r_nxt.done = 1'b0;
    r_nxt.refused = 1'b0;
    r_nxt.accel = i_accel_req;
    if (eng_req) begin
      r_nxt.sent = 1'b1;
    end
    if (i_start && (r_r.st != ST_IDLE) && !susp_ok) begin
      r_nxt.refused = 1'b1;
    end
    unique case (r_r.st)
      ST_IDLE: if (i_start) begin
        if (allowed) begin
          r_nxt.op = i_op;
          r_nxt.addr = i_addr;
          r_nxt.data = i_data;
          r_nxt.byp_op = byp_eff;
          r_nxt.idx = 3'h0;
          r_nxt.sent = 1'b0;
          r_nxt.fail = 1'b0;
          r_nxt.st = ST_SEQ;
          if (i_op == OP_RESUME) begin
            r_nxt.suspended = 1'b0;
          end
        end else begin
          r_nxt.refused = 1'b1;
        end
      end
      ST_SEQ: if (r_r.sent && eng_done) begin
        r_nxt.sent = 1'b0;
        if (r_r.idx != seq_last(r_r.op, r_r.byp_op)) begin
          r_nxt.idx = r_r.idx + 3'h1;
        end else begin
          r_nxt.st = ST_IDLE;
          r_nxt.done = 1'b1;
          case (r_r.op)
            OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_RESUME: begin
              // no wait is inserted: the device times the operation itself
              r_nxt.st = ST_POLL1;
              r_nxt.done = 1'b0;
              r_nxt.t5 = 1'b0;
              if (r_r.op == OP_SECTOR_ERASE) begin
                r_nxt.erase_run = 1'b1;
              end
            end
            OP_SUSPEND: begin
              r_nxt.st = ST_SUSP_WAIT;
              r_nxt.done = 1'b0;
              r_nxt.susp_cnt = '0;
            end
            OP_READ:         r_nxt.rdata = eng_rdata;
            OP_BYPASS_ENTER: r_nxt.bypass = 1'b1;
            OP_BYPASS_RESET: r_nxt.bypass = 1'b0;
            default:         r_nxt.bypass = r_r.bypass;
          endcase
        end
      end
      ST_POLL1: begin
        if (susp_ok) begin
          r_nxt.op = OP_SUSPEND;
          r_nxt.idx = 3'h0;
          r_nxt.st = ST_SEQ;
        end else if (r_r.sent && eng_done) begin
          r_nxt.sent = 1'b0;
          r_nxt.bit6 = eng_rdata[TOGGLE_BIT];
          r_nxt.st = ST_POLL2;
        end
      end
      ST_POLL2: if (r_r.sent && eng_done) begin
        r_nxt.sent = 1'b0;
        r_nxt.st = ST_POLL1;
        if (eng_rdata[TOGGLE_BIT] == r_r.bit6) begin
          // toggle stopped: finished, device is reading array data again
          r_nxt.st = ST_IDLE;
          r_nxt.done = 1'b1;
          r_nxt.rdata = eng_rdata;
          r_nxt.erase_run = 1'b0;
        end else if (eng_rdata[TIMEOUT_BIT]) begin
          // toggle may stop just as the flag rises, so confirm once more
          if (r_r.t5) begin
            r_nxt.fail = 1'b1;
            r_nxt.erase_run = 1'b0;
            r_nxt.op = OP_RESET;
            r_nxt.idx = 3'h0;
            r_nxt.st = ST_SEQ;
          end else begin
            r_nxt.t5 = 1'b1;
          end
        end
      end
      ST_SUSP_WAIT: begin
        if (r_r.susp_cnt == SUSP_W'(SUSP_WAIT_CYC - 1)) begin
          r_nxt.suspended = 1'b1;
          r_nxt.done = 1'b1;
          r_nxt.st = ST_IDLE;
        end else begin
          r_nxt.susp_cnt = r_r.susp_cnt + SUSP_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '{st: ST_IDLE, op: OP_READ, default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  fsq_bus_cycle u_cycle (
    .i_clock        (i_clock),
    .i_rst_n        (rst_n),
    .i_req          (eng_req),
    .i_write        (eng_write),
    .i_addr         (r_r.st == ST_SEQ ? cur_word[ADDR_W+DATA_W-1:DATA_W] : r_r.addr),
    .i_wdata        (cur_word[DATA_W-1:0]),
    .o_idle         (eng_idle),
    .o_done         (eng_done),
    .o_rdata        (eng_rdata),
    .o_flash_ce_n   (o_flash_ce_n),
    .o_flash_we_n   (o_flash_we_n),
    .o_flash_oe_n   (o_flash_oe_n),
    .o_flash_addr   (o_flash_addr),
    .o_flash_dq_out (o_flash_dq_out),
    .o_flash_dq_oe  (o_flash_dq_oe),
    .i_flash_dq     (i_flash_dq)
  );

  assign o_ready                = (r_r.st == ST_IDLE);
  assign o_done                 = r_r.done;
  assign o_refused              = r_r.refused;
  assign o_fail                 = r_r.fail;
  assign o_rdata                = r_r.rdata;
  assign o_bypass               = byp_eff;
  assign o_suspended            = r_r.suspended;
  assign o_high_program_voltage = r_r.accel;

  logic       we_q;
  logic [2:0] we_cnt;
  logic       seq_to_poll;
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      we_q <= 1'b1;
      we_cnt <= 3'h0;
    end else begin
      we_q <= o_flash_we_n;
      if (r_r.st == ST_IDLE) begin
        we_cnt <= 3'h0;
      end else if (o_flash_we_n && !we_q) begin
        we_cnt <= we_cnt + 3'h1;
      end
    end
  end
  assign seq_to_poll = (r_r.st == ST_SEQ) && (r_nxt.st == ST_POLL1);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n);

  sequence s_sector_last;
    (r_r.st == ST_SEQ) && (r_r.op == OP_SECTOR_ERASE) && (r_r.idx == 3'h5) && eng_req;
  endsequence

  chk_prog_len: assert property ((seq_to_poll && r_r.op == OP_PROGRAM && !r_r.byp_op) |-> we_cnt == 3'h4)
    else $error("normal program not four writes");
  chk_bypass_len: assert property ((seq_to_poll && r_r.op == OP_PROGRAM && r_r.byp_op) |-> we_cnt == 3'h2)
    else $error("bypass program not two writes");
  chk_erase_len: assert property ((seq_to_poll && (r_r.op == OP_CHIP_ERASE || r_r.op == OP_SECTOR_ERASE))
                                  |-> we_cnt == 3'h6)
    else $error("erase not six writes");
  // a busy order may coincide with the running one finishing; it is still refused
  chk_busy_refuse: assert property ((i_start && !o_ready && !susp_ok) |=> o_refused && (!o_ready || o_done))
    else $error("order taken while busy");
  chk_bypass_only: assert property ((o_ready && i_start && o_bypass && (i_op == OP_CHIP_ERASE || i_op == OP_SECTOR_ERASE))
                                    |=> o_refused && o_ready)
    else $error("erase sent in bypass mode");
  chk_sector_addr: assert property (s_sector_last |=> ##[1:20] (!o_flash_ce_n && (o_flash_addr & ~SECTOR_MASK) == '0))
    else $error("sector address has low bits");
  chk_suspend_wait: assert property ($rose(o_suspended) |-> $past(r_r.susp_cnt) == SUSP_W'(SUSP_WAIT_CYC - 1))
    else $error("suspend wait cut short");
  chk_fail_reset: assert property ($rose(o_fail) |-> (r_r.op == OP_RESET && r_r.st == ST_SEQ))
    else $error("failure without reset write");
endmodule : fsq_host
`default_nettype wire

// ---- fsq_pkg_unused_guard.sv ----
// intentionally empty: no further content
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ---- fsq_flash_model.sv ----
// behavioural flash device on the far side of the strobe bus
`timescale 1ns/1ns
`default_nettype none
module fsq_flash_model
  import fsq_pkg::*;
(
  input  wire logic              i_ce_n,
  input  wire logic              i_we_n,
  input  wire logic              i_oe_n,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_dq,
  input  wire logic              i_accel,
  input  wire logic              i_stuck,
  output logic      [DATA_W-1:0] o_dq
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] la;
  logic [DATA_W-1:0] val = '0;
  logic              byp = 0, tog = 0, sect = 0, susp = 0;
  int                step = 0, busy = 0;
  wire               wr_n = i_ce_n | i_we_n;
  wire               rd_n = i_ce_n | i_oe_n;
  always @(negedge wr_n) la = i_addr;
  always @(posedge wr_n) begin
    if (busy > 0) begin
      if (sect && i_dq == CMD_SUSPEND) susp = 1;
      else if (susp && i_dq == CMD_RESUME) susp = 0;
      else if (i_stuck && i_dq == CMD_RESET) busy = 0;
    end else if (step == 10) begin
      mem[la] = (mem.exists(la) ? mem[la] : 16'hffff) & i_dq;
      busy = 3;
      step = 0;
    end else if (step == 20) begin
      byp = 0;
      step = 0;
    end else if ((byp || i_accel) && step == 0)
      step = i_dq == CMD_PROGRAM ? 10 : i_dq == CMD_BYP_RESET1 ? 20 : 0;
    else if (i_dq == CMD_RESET) step = 0;
    else case (step)
      0: step = (i_dq == CMD_UNLOCK1 && la == UNLOCK_ADDR1) ? 1 : 0;
      1, 4: step = (i_dq == CMD_UNLOCK2 && la == UNLOCK_ADDR2) ? step + 1 : 0;
      2: begin
        byp = i_dq == CMD_BYP_ENTER;
        step = i_dq == CMD_PROGRAM ? 10 : i_dq == CMD_ERASE_SET ? 3 : 0;
      end
      3: step = (i_dq == CMD_UNLOCK1) ? 4 : 0;
      5: begin
        sect = i_dq == CMD_SECT_ERASE;
        foreach (mem[k]) if (!sect || (k & SECTOR_MASK) == (la & SECTOR_MASK)) mem[k] = 16'hffff;
        busy = 8;
        step = 0;
      end
      default: step = 0;
    endcase
  end
  always @(negedge rd_n) begin
    // address settles in the same step as the strobes
    #1;
    if (busy > 0 && !susp) begin
      tog = ~tog;
      if (!i_stuck) busy = busy - 1;
    end
    val = (busy > 0 && !susp) ? {9'h0, tog, i_stuck, 5'h0} : mem.exists(i_addr) ? mem[i_addr] : 16'hffff;
  end
  // released bus shows the inverse so stale data never passes
  assign o_dq = rd_n ? ~val : val;
endmodule : fsq_flash_model
`default_nettype wire

// ---- test_flash_program_erase_command_sequencer.sv ----
// self-checking bench of the sequencer host against the device model
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin mismatches++; $display("unexpected %s %h %h", n, e, s); end end
module test_flash_program_erase_command_sequencer
  import fsq_pkg::*;
;
  logic              i_clock, i_nrst, start, accel, stuck, ready, done, refused, fail, byp, susp, hv;
  logic              ce_n, we_n, oe_n, oe;
  fsq_op_t           op;
  logic [ADDR_W-1:0] addr, fa;
  logic [DATA_W-1:0] data, rdata, dqo, dqm;
  int                mismatches, checks_done;
  fsq_host #(.SUSP_WAIT_CYC(8)) u_dut (.i_clock, .i_nrst, .i_start(start), .i_op(op), .i_addr(addr),
    .i_data(data), .i_accel_req(accel), .o_ready(ready), .o_done(done), .o_refused(refused), .o_fail(fail),
    .o_rdata(rdata), .o_bypass(byp), .o_suspended(susp), .o_high_program_voltage(hv), .o_flash_ce_n(ce_n),
    .o_flash_we_n(we_n), .o_flash_oe_n(oe_n), .o_flash_addr(fa), .o_flash_dq_out(dqo), .o_flash_dq_oe(oe),
    .i_flash_dq(oe ? dqo : dqm));
  fsq_flash_model u_flash (.i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_addr(fa), .i_dq(dqo),
    .i_accel(hv), .i_stuck(stuck), .o_dq(dqm));
  initial begin
    i_clock = 0;
    forever #2 i_clock = ~i_clock;
  end
  task automatic fin;
    for (int n = 0; n < 9000 && done !== 1 && refused !== 1; n++) @(posedge i_clock) #1;
    if (done !== 1 && refused !== 1) mismatches++;
  endtask : fin
  task automatic go(input fsq_op_t o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input bit wt);
    @(posedge i_clock) #1;
    {start, op, addr, data} = {1'b1, o, a, d};
    @(posedge i_clock) #1;
    start = 0;
    if (wt) fin;
  endtask : go
  task automatic t_prog;
    go(OP_PROGRAM, 21'h001234, 16'h00f0, 1);
    go(OP_READ, 21'h001234, 16'h0, 1);
    `CHK("read", 16'h00f0, rdata)
    go(OP_PROGRAM, 21'h001234, 16'h0f0f, 0);
    go(OP_READ, 21'h001234, 16'h0, 1);
    `CHK("refused", 1'b1, refused)
    @(posedge i_clock) #1;
    fin;
    go(OP_PROGRAM, 21'h1ff000, 16'h3c3c, 1);
    go(OP_READ, 21'h001234, 16'h0, 1);
    `CHK("read", 16'h0000, rdata)
  endtask : t_prog
  task automatic t_byp;
    go(OP_RESET, 21'h0, 16'h0, 1);
    `CHK("done", 1'b1, done)
    go(OP_BYPASS_ENTER, 21'h0, 16'h0, 1);
    `CHK("bypass", 1'b1, byp)
    go(OP_CHIP_ERASE, 21'h0, 16'h0, 1);
    `CHK("refused", 1'b1, refused)
    go(OP_PROGRAM, 21'h000010, 16'h1234, 1);
    go(OP_READ, 21'h000010, 16'h0, 1);
    `CHK("read", 16'h1234, rdata)
    go(OP_BYPASS_RESET, 21'h0, 16'h0, 1);
    `CHK("bypass", 1'b0, byp)
  endtask : t_byp
  task automatic t_erase;
    go(OP_SECTOR_ERASE, 21'h001abc, 16'h0, 0);
    go(OP_READ, 21'h001234, 16'h0, 1);
    `CHK("refused", 1'b1, refused)
    for (int n = 0; n < 300; n++) begin
      go(OP_SUSPEND, 21'h0, 16'h0, 1);
      if (refused !== 1 && susp === 1) break;
    end
    `CHK("suspended", 1'b1, susp)
    go(OP_SECTOR_ERASE, 21'h1ff000, 16'h0, 1);
    `CHK("refused", 1'b1, refused)
    go(OP_READ, 21'h1ff000, 16'h0, 1);
    `CHK("read", 16'h3c3c, rdata)
    go(OP_RESUME, 21'h0, 16'h0, 1);
    `CHK("suspended", 1'b0, susp)
    go(OP_READ, 21'h001234, 16'h0, 1);
    `CHK("read", 16'hffff, rdata)
    go(OP_CHIP_ERASE, 21'h0, 16'h0, 0);
    go(OP_RESET, 21'h0, 16'h0, 1);
    `CHK("refused", 1'b1, refused)
    @(posedge i_clock) #1;
    fin;
    go(OP_READ, 21'h1ff000, 16'h0, 1);
    `CHK("read", 16'hffff, rdata)
  endtask : t_erase
  task automatic t_fail;
    stuck = 1;
    go(OP_PROGRAM, 21'h000020, 16'h5555, 1);
    `CHK("fail", 1'b1, fail)
    stuck = 0;
    accel = 1;
    go(OP_PROGRAM, 21'h000030, 16'h00aa, 1);
    `CHK("fail", 1'b0, fail)
    `CHK("voltage", 1'b1, hv)
    go(OP_READ, 21'h000030, 16'h0, 1);
    `CHK("read", 16'h00aa, rdata)
  endtask : t_fail
  task automatic end_sim;
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  initial begin
    {i_nrst, start, accel, stuck, op, addr, data, mismatches, checks_done} = '0;
    repeat (2) @(posedge i_clock);
    #1 i_nrst = 1;
    repeat (4) @(posedge i_clock);
    t_prog;
    t_byp;
    t_erase;
    t_fail;
    end_sim;
  end
  initial begin
    #300000;
    mismatches++;
    end_sim;
  end
endmodule : test_flash_program_erase_command_sequencer
`default_nettype wire
